/* msr_regmap.sv */
`timescale 1ns/1ps
`include "msr_defs.svh"

module msr_regmap (
  input wire logic i_clock,                     // System clock, 100 MHz
  input wire logic i_nrst,                      // Async reset, low
  input wire logic i_req_valid,                 // Request present
  input wire msr_pkg::msr_req_t i_req,          // Request contents
  input wire logic [15:0] i_unit_status,        // Unit status from core
  input wire logic [31:0] i_error_status,       // Error status from core
  input wire logic i_new_data,                  // New measurement pulse
  input wire msr_pkg::msr_meas_t i_meas,        // Measurement words
  input wire logic [19:0] i_item_valid,         // Valid flags 48..67
  output logic o_rsp_valid,                     // Answer strobe
  output msr_pkg::msr_rsp_t o_rsp,              // Answer contents
  output logic o_new_data                       // Pending new-data flag
);
  import msr_pkg::*;

  // Registered state
  logic new_data_ff;      // Pending new measurement flag
  logic nxt_new_data;     // Its next value
  logic rsp_valid_ff;     // Answer strobe
  msr_rsp_t rsp_ff;       // Answer held for the master
  msr_rsp_t nxt_rsp;      // Answer being formed

  // Decode helpers
  logic take;             // Request accepted this cycle
  logic is_disc;          // Discrete read
  logic is_input;         // Input word read
  logic is_hold_rd;       // String word read
  logic is_hold_wr;       // String word write
  logic in_str;           // Address inside string block
  logic [15:0] str_off;   // Offset into string block
  logic [15:0] unit_eff;  // Unit status with sticky new-data bit
  logic [15:0] in_word;   // Selected input register word
  logic disc_bit;         // Selected discrete value
  logic [15:0] str_word;  // Selected string word
  logic [2:0] str_valid;  // User strings valid
  logic clr_new;          // Master read the new-data flag

  // Every request is taken; there is no back-pressure
  assign take = i_req_valid;
  assign is_disc = (i_req.func == `MSR_FC_READ_DISC);
  assign is_input = (i_req.func == `MSR_FC_READ_INPUT);
  assign is_hold_rd = (i_req.func == `MSR_FC_READ_HOLD);
  assign is_hold_wr = (i_req.func == `MSR_FC_WRITE_SINGLE);

  assign in_str = (i_req.addr >= `MSR_STR_FIRST) &&
                  (i_req.addr <= `MSR_STR_LAST);
  assign str_off = i_req.addr - `MSR_STR_FIRST;

  // The new-data bit is replaced by our own sticky copy, so the
  // master sees a flag that drops only on reset or when it has really looked
  assign unit_eff = {i_unit_status[15], new_data_ff, i_unit_status[13:0]};

  assign clr_new = take && ((is_input && i_req.addr == `MSR_IN_UNIT) ||
                   (is_disc && i_req.addr == `MSR_DISC_NEW_DATA));

  // Set beats clear so a result landing on a read is not lost
  always_comb begin
    nxt_new_data = new_data_ff;
    if (clr_new) begin
      nxt_new_data = 1'b0;
    end
    if (i_new_data) begin
      nxt_new_data = 1'b1;
    end
  end

  // Pending new-data flag
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      new_data_ff <= 1'b0;
    end else begin
      new_data_ff <= nxt_new_data;
    end
  end

  // User string storage
  msr_strings #(
    .WORDS(`MSR_STR_WORDS),
    .COUNT(`MSR_STR_COUNT)
  ) u_strings (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_wr(take && is_hold_wr && in_str),
    .i_widx(str_off[4:0]),
    .i_wdata(i_req.wdata),
    .i_ridx(str_off[4:0]),
    .o_rdata(str_word),
    .o_valid(str_valid)
  );

  // Discrete bit map
  msr_discretes u_discretes (
    .i_unit(unit_eff),
    .i_error(i_error_status),
    .i_item_valid(i_item_valid),
    .i_str_valid(str_valid),
    .i_addr(i_req.addr),
    .o_bit(disc_bit)
  );

  // Input register word select
  always_comb begin
    in_word = 16'h0000;
    unique case (i_req.addr)
      `MSR_IN_UNIT: in_word = unit_eff;
      `MSR_IN_ERR_HI: in_word = i_error_status[31:16];
      `MSR_IN_ERR_LO: in_word = i_error_status[15:0];
      `MSR_IN_H2_HI: in_word = i_meas.hydrogen[31:16];
      `MSR_IN_H2_LO: in_word = i_meas.hydrogen[15:0];
      `MSR_IN_DAY_HI: in_word = i_meas.daily[31:16];
      `MSR_IN_DAY_LO: in_word = i_meas.daily[15:0];
      `MSR_IN_WEEK_HI: in_word = i_meas.weekly[31:16];
      `MSR_IN_WEEK_LO: in_word = i_meas.weekly[15:0];
      `MSR_IN_MONTH_HI: in_word = i_meas.monthly[31:16];
      `MSR_IN_MONTH_LO: in_word = i_meas.monthly[15:0];
      `MSR_IN_LIQ_HI: in_word = i_meas.liquid_temp[31:16];
      `MSR_IN_LIQ_LO: in_word = i_meas.liquid_temp[15:0];
      default: in_word = 16'h0000;
    endcase
  end

  // Answer formation; refusals carry a code and zero data
  always_comb begin
    nxt_rsp = '0;
    if (is_disc) begin
      if (i_req.addr <= `MSR_DISC_LAST) begin
        nxt_rsp.data = {15'h0000, disc_bit};
      end else begin
        nxt_rsp.exc = 1'b1;
        nxt_rsp.exc_code = `MSR_EXC_ILL_ADDR;
      end
    end else if (is_input) begin
      if (i_req.addr <= `MSR_IN_LAST) begin
        nxt_rsp.data = in_word;
      end else begin
        nxt_rsp.exc = 1'b1;
        nxt_rsp.exc_code = `MSR_EXC_ILL_ADDR;
      end
    end else if (is_hold_rd || is_hold_wr) begin
      if (in_str) begin
        nxt_rsp.data = is_hold_rd ? str_word : i_req.wdata;
      end else begin
        nxt_rsp.exc = 1'b1;
        nxt_rsp.exc_code = `MSR_EXC_ILL_ADDR;
      end
    end else begin
      // Read-only spaces have no write function
      nxt_rsp.exc = 1'b1;
      nxt_rsp.exc_code = `MSR_EXC_ILL_FUNC;
    end
  end

  // Answer registers, one cycle after the request
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= take;
    end
  end

  // Answer data held until the next request
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_ff <= '0;
    end else if (take) begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign o_rsp_valid = rsp_valid_ff;
  assign o_rsp = rsp_ff;
  assign o_new_data = new_data_ff;

  // Checks on the answer path and the new-data flag
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  logic rd_in;   // Input read taken
  logic rd_disc; // Discrete read taken
  assign rd_in = take && is_input;
  assign rd_disc = take && is_disc;

  rsp_timing_a: assert property (
    take |=> o_rsp_valid ##1 (o_rsp_valid == $past(take)))
    else $error("answer strobe not one cycle after request");

  err_split_a: assert property (
    rd_in && i_req.addr == `MSR_IN_ERR_LO
    |=> o_rsp.data == $past(i_error_status[15:0]) && !o_rsp.exc)
    else $error("error status low word wrong");

  hydro_word_a: assert property (
    rd_in && i_req.addr == `MSR_IN_H2_HI
    |=> o_rsp.data == $past(i_meas.hydrogen[31:16]))
    else $error("hydrogen high word wrong");

  month_rate_a: assert property (
    rd_in && i_req.addr == `MSR_IN_MONTH_LO
    |=> o_rsp.data == $past(i_meas.monthly[15:0]))
    else $error("monthly rate low word wrong");

  liquid_temp_a: assert property (
    rd_in && i_req.addr == `MSR_IN_LIQ_HI
    |=> o_rsp.data == $past(i_meas.liquid_temp[31:16]))
    else $error("liquid temperature high word wrong");

  reserved_zero_a: assert property (
    rd_in && i_req.addr == `MSR_IN_RSVD_A
    |=> o_rsp.data == 16'h0000 && !o_rsp.exc)
    else $error("reserved input word not zero");

  ready_bit_a: assert property (
    rd_disc && i_req.addr == `MSR_DISC_READY
    |=> o_rsp.data == {15'h0000, $past(i_unit_status[15])})
    else $error("ready discrete wrong");

  new_clear_a: assert property (
    clr_new && !i_new_data |=> !o_new_data ##1 (o_new_data == $past(i_new_data)))
    else $error("new data flag not cleared by read");

  new_set_a: assert property (
    i_new_data |=> o_new_data)
    else $error("new data flag lost");

  cal_state_a: assert property (
    rd_disc && i_req.addr == (`MSR_DISC_STATE_BASE + 16'h0002)
    |=> o_rsp.data[0] == ($past(i_unit_status[5:3]) == 3'h3))
    else $error("calibration state discrete wrong");

  heater_bit_a: assert property (
    rd_disc && i_req.addr == `MSR_DISC_HEATER
    |=> o_rsp.data[0] == $past(i_error_status[31]))
    else $error("heater fault discrete wrong");

  owner_valid_a: assert property (
    rd_disc && i_req.addr == `MSR_DISC_OWNER_VALID
    |=> o_rsp.data[0] == $past(str_valid[0]))
    else $error("owner valid discrete wrong");

  str_readback_a: assert property (
    (take && is_hold_wr && i_req.addr == 16'h00D3)
    ##1 (take && is_hold_rd && i_req.addr == 16'h00D3)
    |=> o_rsp.data == $past(i_req.wdata, 2))
    else $error("substation string word not stored");

  str_null_a: assert property (
    take && is_hold_rd && i_req.addr == 16'h00D2
    |=> o_rsp.data[7:0] == 8'h00)
    else $error("owner string lost its terminator");

  fatal_bit_a: assert property (
    rd_disc && i_req.addr == `MSR_DISC_FATAL
    |=> o_rsp.data[0] == $past(i_unit_status[12]))
    else $error("fatal error discrete wrong");

  tsens_bit_a: assert property (
    rd_disc && i_req.addr == (`MSR_DISC_HEATER + 16'h0001)
    |=> o_rsp.data[0] == $past(i_error_status[30]))
    else $error("sensor fault discrete wrong");

  rtc_bit_a: assert property (
    rd_disc && i_req.addr == `MSR_DISC_RTC_BAD
    |=> o_rsp.data[0] == $past(i_error_status[8]))
    else $error("clock invalid discrete wrong");

  internal_bit_a: assert property (
    rd_disc && i_req.addr == (`MSR_DISC_RTC_BAD + 16'h0002)
    |=> o_rsp.data[0] == $past(i_error_status[3]))
    else $error("internal error discrete wrong");

  spare_disc_a: assert property (
    rd_disc && i_req.addr >= 16'h0007 && i_req.addr <= 16'h000F
    |=> o_rsp.data == 16'h0000 && !o_rsp.exc)
    else $error("spare discrete not zero");

  disc_range_a: assert property (
    rd_disc && i_req.addr > `MSR_DISC_LAST
    |=> o_rsp.exc && o_rsp.exc_code == `MSR_EXC_ILL_ADDR)
    else $error("discrete beyond range not refused");

  input_range_a: assert property (
    rd_in && i_req.addr > `MSR_IN_LAST
    |=> o_rsp.exc && o_rsp.exc_code == `MSR_EXC_ILL_ADDR)
    else $error("input word beyond range not refused");

  unit_word_a: assert property (
    rd_in && i_req.addr == `MSR_IN_UNIT
    |=> o_rsp.data == {$past(i_unit_status[15]), $past(new_data_ff),
                       $past(i_unit_status[13:0])})
    else $error("unit status word wrong");

  str_echo_a: assert property (
    take && is_hold_wr && in_str
    |=> o_rsp.data == $past(i_req.wdata) && !o_rsp.exc)
    else $error("string write not echoed");

  hold_range_a: assert property (
    take && (is_hold_rd || is_hold_wr) && !in_str
    |=> o_rsp.exc && o_rsp.exc_code == `MSR_EXC_ILL_ADDR)
    else $error("holding access outside strings not refused");

  // Main scenarios
  cover_str_rw: cover property (
    (take && is_hold_wr && in_str) ##1 (take && is_hold_rd && in_str));
  cover_new_clr: cover property (o_new_data ##1 clr_new ##1 !o_new_data);
  cover_bad_func: cover property (o_rsp_valid && o_rsp.exc &&
    o_rsp.exc_code == `MSR_EXC_ILL_FUNC);
  cover_disc_one: cover property (o_rsp_valid && !o_rsp.exc &&
    o_rsp.data == 16'h0001);
endmodule : msr_regmap

/* msr_defs.svh */
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH

// Function codes understood by the register bank
`define MSR_FC_READ_DISC 8'h02
`define MSR_FC_READ_HOLD 8'h03
`define MSR_FC_READ_INPUT 8'h04
`define MSR_FC_WRITE_SINGLE 8'h06

// Exception codes returned with a refused request
`define MSR_EXC_ILL_FUNC 8'h01
`define MSR_EXC_ILL_ADDR 8'h02

// Discrete input space
`define MSR_DISC_LAST 16'h0043
`define MSR_DISC_READY 16'h0000
`define MSR_DISC_NEW_DATA 16'h0001
`define MSR_DISC_FATAL 16'h0002
`define MSR_DISC_STATE_BASE 16'h0003
`define MSR_DISC_HEATER 16'h0010
`define MSR_DISC_RTC_BAD 16'h0013
`define MSR_DISC_VALID_BASE 16'h0030
`define MSR_DISC_OWNER_VALID 16'h0040

// Input register space
`define MSR_IN_LAST 16'h000E
`define MSR_IN_UNIT 16'h0000
`define MSR_IN_ERR_HI 16'h0001
`define MSR_IN_ERR_LO 16'h0002
`define MSR_IN_H2_HI 16'h0003
`define MSR_IN_H2_LO 16'h0004
`define MSR_IN_DAY_HI 16'h0005
`define MSR_IN_DAY_LO 16'h0006
`define MSR_IN_WEEK_HI 16'h0007
`define MSR_IN_WEEK_LO 16'h0008
`define MSR_IN_MONTH_HI 16'h0009
`define MSR_IN_MONTH_LO 16'h000A
`define MSR_IN_RSVD_A 16'h000B
`define MSR_IN_RSVD_B 16'h000C
`define MSR_IN_LIQ_HI 16'h000D
`define MSR_IN_LIQ_LO 16'h000E

// User string holding registers
`define MSR_STR_FIRST 16'h00C9
`define MSR_STR_LAST 16'h00E6
`define MSR_STR_WORDS 10
`define MSR_STR_COUNT 3
`define MSR_STR_RESET 16'h0000

// Unit status field positions
`define MSR_US_READY 15
`define MSR_US_NEW_DATA 14
`define MSR_US_FATAL 12
`define MSR_US_STATE_MSB 5
`define MSR_US_STATE_LSB 3

// Error status field positions
`define MSR_ES_HEATER 31
`define MSR_ES_TSENS_A 30
`define MSR_ES_TSENS_B 29
`define MSR_ES_RTC_BAD 8
`define MSR_ES_OVER_TEMP 4
`define MSR_ES_INTERNAL 3

// Valid-flag slots that carry no item, and the first user-string slot
`define MSR_VAL_RSVD_A 4
`define MSR_VAL_RSVD_B 12
`define MSR_VAL_STR_BASE 16

`endif

/* msr_pkg.sv */
package msr_pkg;
  // One register request from the serial front end
  typedef struct packed {
    logic [7:0] func;   // Function code
    logic [15:0] addr;  // Data address
    logic [15:0] wdata; // Write value
  } msr_req_t;

  // Answer to one request
  typedef struct packed {
    logic [15:0] data;    // Read value
    logic exc;            // Request refused
    logic [7:0] exc_code; // Reason when refused
  } msr_rsp_t;

  // Floating-point measurements, IEEE single words
  typedef struct packed {
    logic [31:0] hydrogen;
    logic [31:0] daily;
    logic [31:0] weekly;
    logic [31:0] monthly;
    logic [31:0] liquid_temp;
  } msr_meas_t;
endpackage : msr_pkg

/* msr_strings.sv */
`timescale 1ns/1ps
`include "msr_defs.svh"

module msr_strings #(
  parameter int WORDS = `MSR_STR_WORDS,
  parameter int COUNT = `MSR_STR_COUNT
) (
  input wire logic i_clock,                   // System clock
  input wire logic i_nrst,                    // Async reset, low
  input wire logic i_wr,                      // Word write strobe
  input wire logic [4:0] i_widx,              // Word index to write
  input wire logic [15:0] i_wdata,            // Two characters
  input wire logic [4:0] i_ridx,              // Word index to read
  output logic [15:0] o_rdata,                // Word read back
  output logic [COUNT-1:0] o_valid            // String holds content
);
  import msr_pkg::*;

  // Character storage, two characters a word, high byte first
  logic [15:0] mem_ff [0:WORDS*COUNT-1];

  // Write port; the final byte of each string is kept as the null
  // terminator always kept
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < WORDS*COUNT; i++) begin
        mem_ff[i] <= `MSR_STR_RESET;
      end
    end else if (i_wr) begin
      if ((int'(i_widx) % WORDS) == WORDS - 1) begin
        // Last word: only one character fits before the null
        mem_ff[i_widx] <= {i_wdata[15:8], 8'h00};
      end else begin
        mem_ff[i_widx] <= i_wdata;
      end
    end
  end

  // Read port, registered by the caller
  assign o_rdata = mem_ff[i_ridx];

  // A string is valid once its first character is not null
  genvar g;
  generate
    for (g = 0; g < COUNT; g++) begin : g_valid
      assign o_valid[g] = (mem_ff[g*WORDS][15:8] != 8'h00);
    end
  endgenerate
endmodule : msr_strings

/* msr_discretes.sv */
`timescale 1ns/1ps
`include "msr_defs.svh"

module msr_discretes (
  input wire logic [15:0] i_unit,       // Unit status as seen by master
  input wire logic [31:0] i_error,      // Error status
  input wire logic [19:0] i_item_valid, // Item valid flags from outside
  input wire logic [2:0] i_str_valid,   // User string valid flags
  input wire logic [15:0] i_addr,       // Discrete data address
  output logic o_bit                    // Selected discrete value
);
  import msr_pkg::*;

  logic [67:0] disc; // Whole discrete space, spares at zero
  logic [2:0] state; // Sensor state field

  assign state = i_unit[`MSR_US_STATE_MSB:`MSR_US_STATE_LSB];

  assign disc[0] = i_unit[`MSR_US_READY];
  assign disc[1] = i_unit[`MSR_US_NEW_DATA];
  assign disc[2] = i_unit[`MSR_US_FATAL];
  assign disc[15:7] = '0;
  assign disc[16] = i_error[`MSR_ES_HEATER];
  assign disc[17] = i_error[`MSR_ES_TSENS_A];
  assign disc[18] = i_error[`MSR_ES_TSENS_B];
  assign disc[19] = i_error[`MSR_ES_RTC_BAD];
  assign disc[20] = i_error[`MSR_ES_OVER_TEMP];
  assign disc[21] = i_error[`MSR_ES_INTERNAL];
  assign disc[47:22] = '0;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_state
      assign disc[3+g] = (state == 3'(g + 1));
    end
    for (g = 0; g < 20; g++) begin : g_item
      if (g == `MSR_VAL_RSVD_A || g == `MSR_VAL_RSVD_B) begin : g_rsvd
        assign disc[48+g] = 1'b0;
      end else if (g >= `MSR_VAL_STR_BASE && g < `MSR_VAL_STR_BASE + 3)
      begin : g_str
        // User strings are judged by their own storage
        assign disc[48+g] = i_str_valid[g-`MSR_VAL_STR_BASE];
      end else begin : g_ext
        assign disc[48+g] = i_item_valid[g];
      end
    end
  endgenerate

  // Out-of-range addresses are refused by the caller; read zero here
  assign o_bit = (i_addr <= `MSR_DISC_LAST) ? disc[i_addr[6:0]] : 1'b0;
endmodule : msr_discretes

/* msr_master.sv */
`timescale 1ns/1ps

module msr_master (
  input wire logic i_clock,            // System clock
  output msr_pkg::msr_req_t o_req,     // Request contents
  output logic o_req_valid,            // Request strobe
  input wire logic i_rsp_valid,        // Answer strobe
  input wire msr_pkg::msr_rsp_t i_rsp  // Answer contents
);
  import msr_pkg::*;

  // Quiet bus at time zero
  initial begin
    o_req_valid = 1'b0;
    o_req = '0;
  end

  // One request, answer taken just after the taking edge
  // code plus zero-based data address
  task automatic xfer(input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] w, output msr_rsp_t r,
                      output logic ok);
    @(posedge i_clock);
    #1;
    o_req = '{func: f, addr: a, wdata: w};
    o_req_valid = 1'b1;
    @(posedge i_clock);
    #1;
    ok = i_rsp_valid;
    r = i_rsp;
    o_req_valid = 1'b0;
    // Released lines show the inverse, never a stale request
    o_req = ~o_req;
  endtask : xfer

  // Two requests on consecutive edges, strobe held high between them
  // back-to-back requests
  task automatic pair(input msr_req_t q0, input msr_req_t q1,
                      output msr_rsp_t r0, output msr_rsp_t r1,
                      output logic ok);
    @(posedge i_clock);
    #1;
    o_req = q0;
    o_req_valid = 1'b1;
    @(posedge i_clock);
    #1;
    ok = i_rsp_valid;
    r0 = i_rsp;
    o_req = q1;
    @(posedge i_clock);
    #1;
    ok = ok & i_rsp_valid;
    r1 = i_rsp;
    o_req_valid = 1'b0;
    o_req = ~o_req;
  endtask : pair
endmodule : msr_master

/* msr_regmap_tb.sv */
`timescale 1ns/1ps

module msr_regmap_tb;
  import msr_pkg::*;

  logic i_clock = 1'b0;           // 100 MHz clock
  logic i_nrst = 1'b0;            // Reset, low
  logic i_req_valid;              // Request strobe from master
  msr_req_t i_req;                // Request from master
  logic [15:0] us = 16'h0000;     // Unit status input
  logic [31:0] es = 32'h0000_0000; // Error status input
  logic nd = 1'b0;                // New data pulse
  msr_meas_t meas = '0;           // Measurement words
  logic [19:0] iv = 20'h00000;    // Item valid flags
  logic o_rsp_valid;              // Answer strobe
  msr_rsp_t o_rsp;                // Answer
  logic o_new_data;               // Sticky flag
  logic fl = 1'b0;                // Expected sticky flag
  logic [2:0] sv = 3'b000;        // Expected string valid
  int err_count = 0;              // Mismatches
  int checks = 0;                 // Comparisons
  int cycles = 0;                 // Watchdog count

  always #5 i_clock = ~i_clock;

  msr_regmap dut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_req_valid(i_req_valid),
    .i_req(i_req), .i_unit_status(us), .i_error_status(es),
    .i_new_data(nd), .i_meas(meas), .i_item_valid(iv),
    .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_new_data(o_new_data)
  );

  msr_master m (
    .i_clock(i_clock), .o_req(i_req), .o_req_valid(i_req_valid),
    .i_rsp_valid(o_rsp_valid), .i_rsp(o_rsp)
  );

  // Watchdog; whole run needs well under two thousand cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Accepted request: answer on time, no refusal, expected word
  task automatic rd(input logic [7:0] f, input logic [15:0] a,
                    input logic [15:0] w, input logic [15:0] e);
    msr_rsp_t r;
    logic ok;
    m.xfer(f, a, w, r, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk({15'h0000, r.exc}, 16'h0000);
    chk(r.data, e);
  endtask : rd

  // Refused request: exception with code, data zero
  task automatic bad(input logic [7:0] f, input logic [15:0] a,
                     input logic [7:0] code);
    msr_rsp_t r;
    logic ok;
    m.xfer(f, a, 16'h1234, r, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk({7'h00, r.exc, r.exc_code}, {8'h01, code});
    chk(r.data, 16'h0000);
  endtask : bad

  // Input word expected at each data address
  function automatic logic [15:0] exp_in(input int a);
    case (a)
      0: return {us[15], fl, us[13:0]};
      1: return es[31:16];
      2: return es[15:0];
      3: return meas.hydrogen[31:16];
      4: return meas.hydrogen[15:0];
      5: return meas.daily[31:16];
      6: return meas.daily[15:0];
      7: return meas.weekly[31:16];
      8: return meas.weekly[15:0];
      9: return meas.monthly[31:16];
      10: return meas.monthly[15:0];
      13: return meas.liquid_temp[31:16];
      14: return meas.liquid_temp[15:0];
      default: return 16'h0000; // Reserved words
    endcase
  endfunction : exp_in

  // Discrete bit expected at each data address
  function automatic logic exp_di(input int a);
    if (a == 0) return us[15];
    if (a == 1) return fl;
    if (a == 2) return us[12];
    if (a >= 3 && a <= 6) return us[5:3] == a - 2;
    if (a >= 16 && a <= 18) return es[47 - a];
    if (a == 19) return es[8];
    if (a == 20) return es[4];
    if (a == 21) return es[3];
    if (a >= 64 && a <= 66) return sv[a - 64];
    if (a == 52 || a == 60) return 1'b0;
    if (a >= 48 && a <= 67) return iv[a - 48];
    return 1'b0; // Spare bits
  endfunction : exp_di

  task automatic t_reset();
    chk(o_rsp.data, 16'h0000);
    chk({15'h0000, o_new_data}, 16'h0000);
    rd(8'h03, 16'h00C9, 16'h0000, 16'h0000);
    rd(8'h03, 16'h00E6, 16'h0000, 16'h0000);
    for (int a = 64; a <= 66; a++) rd(8'h02, a, 16'h0000, 16'h0000);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_inputs();
    logic [7:0] fc[4] = '{8'h00, 8'h01, 8'h05, 8'hFF};
    us = 16'hB5E9;
    es = 32'hA5C3_3C5A;
    meas = {32'h1111_2222, 32'h3333_4444, 32'h5555_6666,
            32'h7777_8888, 32'h9999_AAAA};
    for (int a = 0; a <= 14; a++) rd(8'h04, a, 16'h0000, exp_in(a));
    bad(8'h04, 16'h000F, 8'h02);
    bad(8'h04, 16'hFFFF, 8'h02);
    for (int i = 0; i < 4; i++) bad(fc[i], 16'h0000, 8'h01);
    $display("t_inputs done");
  endtask : t_inputs

  task automatic t_disc();
    us = 16'hFFFF;
    es = 32'hFFFF_FFFF;
    iv = 20'hFFFFF;
    for (int a = 0; a <= 67; a++) rd(8'h02, a, 0, exp_di(a));
    us = 16'h9028;
    es = 32'hA000_0118;
    iv = 20'h5A5A5;
    for (int a = 0; a <= 67; a++) rd(8'h02, a, 0, exp_di(a));
    bad(8'h02, 16'h0044, 8'h02);
    for (int c = 0; c < 8; c++) begin
      us = {10'h000, c[2:0], 3'h7};
      for (int a = 3; a <= 6; a++) rd(8'h02, a, 0, exp_di(a));
    end
    $display("t_disc done");
  endtask : t_disc

  task automatic pulse();
    @(posedge i_clock);
    #1;
    nd = 1'b1;
    @(posedge i_clock);
    #1;
    nd = 1'b0;
    fl = 1'b1;
    chk({15'h0000, o_new_data}, 16'h0001);
  endtask : pulse

  task automatic t_newdata();
    pulse();
    rd(8'h04, 16'h0001, 16'h0000, exp_in(1));
    chk({15'h0000, o_new_data}, 16'h0001);
    rd(8'h04, 16'h0000, 16'h0000, exp_in(0));
    fl = 1'b0;
    chk({15'h0000, o_new_data}, 16'h0000);
    pulse();
    rd(8'h02, 16'h0001, 16'h0000, 16'h0001);
    fl = 1'b0;
    rd(8'h02, 16'h0001, 16'h0000, 16'h0000);
    $display("t_newdata done");
  endtask : t_newdata

  task automatic t_strings();
    rd(8'h06, 16'h00C9, 16'h4142, 16'h4142);
    rd(8'h03, 16'h00C9, 16'h0000, 16'h4142);
    sv = 3'b001;
    rd(8'h02, 16'h0040, 16'h0000, 16'h0001);
    rd(8'h06, 16'h00D3, 16'h0041, 16'h0041);
    rd(8'h02, 16'h0041, 16'h0000, 16'h0000);
    rd(8'h06, 16'h00DD, 16'h4300, 16'h4300);
    sv = 3'b101;
    rd(8'h02, 16'h0042, 16'h0000, 16'h0001);
    rd(8'h06, 16'h00D2, 16'h3132, 16'h3132);
    rd(8'h03, 16'h00D2, 16'h0000, 16'h3100);
    rd(8'h03, 16'h00D3, 16'h0000, 16'h0041);
    rd(8'h06, 16'h00E6, 16'h5A5A, 16'h5A5A);
    rd(8'h03, 16'h00E6, 16'h0000, 16'h5A00);
    bad(8'h06, 16'h00C8, 8'h02);
    bad(8'h06, 16'h00E7, 8'h02);
    bad(8'h03, 16'h00E7, 8'h02);
    bad(8'h06, 16'h000B, 8'h02);
    rd(8'h04, 16'h000B, 16'h0000, 16'h0000);
    $display("t_strings done");
  endtask : t_strings

  // Write then read in adjacent cycles; two unit reads in a row
  task automatic t_b2b();
    msr_rsp_t r0;
    msr_rsp_t r1;
    logic ok;
    logic [15:0] e0;
    m.pair(msr_req_t'{8'h06, 16'h00D3, 16'h5354},
           msr_req_t'{8'h03, 16'h00D3, 16'h0000}, r0, r1, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(r0.data, 16'h5354);
    chk(r1.data, 16'h5354);
    sv = 3'b111;
    rd(8'h02, 16'h0041, 16'h0000, 16'h0001);
    pulse();
    e0 = exp_in(0);
    fl = 1'b0;
    m.pair(msr_req_t'{8'h04, 16'h0000, 16'h0000},
           msr_req_t'{8'h04, 16'h0000, 16'h0000}, r0, r1, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(r0.data, e0);
    chk(r1.data, exp_in(0));
    $display("t_b2b done");
  endtask : t_b2b

  // Mid-run reset empties strings and drops the pending flag
  task automatic t_rst2();
    pulse();
    @(posedge i_clock);
    #1;
    i_nrst = 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    fl = 1'b0;
    sv = 3'b000;
    chk({15'h0000, o_new_data}, 16'h0000);
    rd(8'h03, 16'h00D3, 16'h0000, 16'h0000);
    rd(8'h02, 16'h0041, 16'h0000, 16'h0000);
    rd(8'h02, 16'h0001, 16'h0000, 16'h0000);
    $display("t_rst2 done");
  endtask : t_rst2

  initial begin
    repeat (8) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    t_reset();
    t_inputs();
    t_disc();
    t_newdata();
    t_strings();
    t_b2b();
    t_rst2();
    wrap_up();
  end
endmodule : msr_regmap_tb
